/* File: pin_select_pkg.sv */
package pin_select_pkg;

    // pin indices and count
    localparam int unsigned PIN_COUNT     = 3;
    localparam int unsigned PIN_DATA_IN   = 0;
    localparam int unsigned PIN_DATA_OUT  = 1;
    localparam int unsigned PIN_CLOCK     = 2;

    // register byte addresses
    localparam logic [11:0] OFS_PORT_MODE     = 12'h0_000;
    localparam logic [11:0] OFS_WRITE_PROTECT = 12'h0_004;
    localparam logic [11:0] OFS_FUNC_SEL_BASE = 12'h0_010;
    localparam logic [11:0] OFS_FUNC_SEL_STEP = 12'h0_004;

    // field layout
    localparam int unsigned SEL_WIDTH     = 5;
    localparam int unsigned LOCK_BIT_POS  = 7;
    localparam int unsigned WREN_BIT_POS  = 6;

    // values after reset
    localparam logic [2:0]  PORT_MODE_RESET = 3'h0;
    localparam logic        LOCK_RESET      = 1'h1;
    localparam logic        WREN_RESET      = 1'h0;
    localparam logic [4:0]  SEL_RESET       = 5'h00;

    // selection codes
    localparam logic [4:0]  SEL_HIGH_Z      = 5'h00;
    localparam logic [4:0]  SEL_SERIAL      = 5'h0A;

    // idle level offered to the peripheral on an unrouted input
    localparam logic        PERIPH_IDLE_IN  = 1'h1;

    // ahb constants
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
    localparam logic        HRESP_OKAY      = 1'h0;

endpackage : pin_select_pkg

/* File: pin_route_cell.sv */
`timescale 1ns/1ps

module pin_route_cell (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // configuration
    input  wire logic       port_mode_bit,
    input  wire logic [4:0] pin_function_select,
    // port side
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe,
    output logic            gpio_in,
    // peripheral side
    input  wire logic       periph_out,
    input  wire logic       periph_oe,
    output logic            periph_in,
    // package pin
    input  wire logic       pad_in,
    output logic            pad_out,
    output logic            pad_oe
);

    logic serial_routed;
    logic out_next;
    logic oe_next;
    logic pin_in_next;

    // the peripheral owns the pin only with mode set and the serial code chosen
    assign serial_routed = port_mode_bit && (pin_function_select == pin_select_pkg::SEL_SERIAL);
    // mode clear gives the port; mode set with any other code leaves the pin floating
    assign out_next      = !port_mode_bit ? gpio_out : (serial_routed ? periph_out : 1'b0);
    assign oe_next       = !port_mode_bit ? gpio_oe  : (serial_routed && periph_oe);
    // unrouted peripheral input sees idle so no false edge reaches it
    assign pin_in_next   = serial_routed ? pad_in : pin_select_pkg::PERIPH_IDLE_IN;

    // registered pad drive and input capture; one cycle of latency each way
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out   <= 1'b0;
            pad_oe    <= 1'b0;
            gpio_in   <= 1'b0;
            periph_in <= pin_select_pkg::PERIPH_IDLE_IN;
        end else begin
            pad_out   <= out_next;
            pad_oe    <= oe_next;
            gpio_in   <= pad_in;
            periph_in <= pin_in_next;
        end
    end

endmodule : pin_route_cell

/* File: pin_function_select_protect.sv */
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module pin_function_select_protect #(
    parameter int unsigned NPINS = pin_select_pkg::PIN_COUNT
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [11:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // general-purpose port side, one bit per pin
    input  wire logic [NPINS-1:0]  gpio_out,
    input  wire logic [NPINS-1:0]  gpio_oe,
    output logic [NPINS-1:0]       gpio_in,
    // serial peripheral side: bit 0 receive, bit 1 transmit, bit 2 clock
    input  wire logic [NPINS-1:0]  periph_out,
    input  wire logic [NPINS-1:0]  periph_oe,
    output logic [NPINS-1:0]       periph_in,
    // package pins: serial_input_pin, serial_output_pin, clock pin
    input  wire logic [NPINS-1:0]  pad_in,
    output logic [NPINS-1:0]       pad_out,
    output logic [NPINS-1:0]       pad_oe
);

    //////////////////////////////////////////////////////////////////////////
    // address helpers

    // index of a select register at this address, or NPINS when none
    function automatic int unsigned sel_index(input logic [11:0] addr);
        int unsigned idx;
        idx = NPINS;
        for (int unsigned i = 0; i < NPINS; i++) begin
            if (addr == 12'(pin_select_pkg::OFS_FUNC_SEL_BASE + 12'(i) * pin_select_pkg::OFS_FUNC_SEL_STEP)) begin
                idx = i;
            end
        end
        return idx;
    endfunction : sel_index

    // true when the address hits the port mode register
    function automatic logic is_mode_addr(input logic [11:0] addr);
        return (addr == pin_select_pkg::OFS_PORT_MODE);
    endfunction : is_mode_addr

    // true when the address hits the write-protect register
    function automatic logic is_protect_addr(input logic [11:0] addr);
        return (addr == pin_select_pkg::OFS_WRITE_PROTECT);
    endfunction : is_protect_addr

    //////////////////////////////////////////////////////////////////////////
    // register state

    logic [NPINS-1:0]     port_mode_bits_reg;
    logic                 protect_lock_bit_reg;
    logic                 select_write_enable_reg;
    logic [4:0]           pin_function_select_reg [NPINS];

    logic                 wr_pend_reg;
    logic [11:0]          wr_addr_reg;

    //////////////////////////////////////////////////////////////////////////
    // address phase decode

    logic                 addr_valid;
    logic                 rd_take;
    logic                 wr_take;
    logic                 rd_mode;
    logic                 rd_protect;
    int unsigned          rd_sel_idx;
    logic [31:0]          rd_word;

    // hsize is not decoded: every register is one word, so a narrower access
    // simply updates the whole word
    // only nonseq or seq transfers with hready high are taken
    assign addr_valid = hsel && hready && (htrans == pin_select_pkg::HTRANS_NONSEQ
                                        || htrans == pin_select_pkg::HTRANS_SEQ);
    assign rd_take    = addr_valid && !hwrite;
    assign wr_take    = addr_valid && hwrite;
    assign rd_mode    = is_mode_addr(haddr);
    assign rd_protect = is_protect_addr(haddr);
    assign rd_sel_idx = sel_index(haddr);

    // the word is captured at the address edge, so writes that already landed show
    // read mux; unmapped addresses and reserved bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (rd_mode) begin
            rd_word[NPINS-1:0] = port_mode_bits_reg;
        end else if (rd_protect) begin
            rd_word[pin_select_pkg::LOCK_BIT_POS] = protect_lock_bit_reg;
            rd_word[pin_select_pkg::WREN_BIT_POS] = select_write_enable_reg;
        end else if (rd_sel_idx < NPINS) begin
            rd_word[pin_select_pkg::SEL_WIDTH-1:0] = pin_function_select_reg[rd_sel_idx];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // data phase write decode

    logic                 wr_mode;
    logic                 wr_protect;
    logic                 wr_sel_ok;
    int unsigned          wr_sel_idx;
    logic                 lock_next;
    logic                 wren_next;
    logic                 wren_open;
    logic [NPINS-1:0]     sel_wr_hit;

    assign wr_mode    = wr_pend_reg && is_mode_addr(wr_addr_reg);
    assign wr_protect = wr_pend_reg && is_protect_addr(wr_addr_reg);
    assign wr_sel_idx = sel_index(wr_addr_reg);
    // select writes are dropped silently while write-enable is clear
    assign wr_sel_ok  = wr_pend_reg && (wr_sel_idx < NPINS) && select_write_enable_reg;
    // lock bit is always writable; write-enable follows it only while unlocked,
    // judged on the lock value before this write so one word cannot unlock and enable
    assign lock_next  = wr_protect ? hwdata[pin_select_pkg::LOCK_BIT_POS] : protect_lock_bit_reg;
    assign wren_open  = wr_protect && !protect_lock_bit_reg;
    assign wren_next  = wren_open ? hwdata[pin_select_pkg::WREN_BIT_POS] : select_write_enable_reg;

    // one strobe per select register, already gated by write-enable;
    // a blocked write still answers okay, software sees no error
    for (genvar s = 0; s < NPINS; s++) begin : g_sel_hit
        assign sel_wr_hit[s] = wr_sel_ok && (wr_sel_idx == s);
    end

    //////////////////////////////////////////////////////////////////////////
    // bus pipeline; zero wait states, always okay

    // the write address is held over to the data phase, when hwdata arrives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h0_000;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= pin_select_pkg::HRESP_OKAY;
        end else begin
            wr_pend_reg <= wr_take;
            wr_addr_reg <= wr_take ? haddr : wr_addr_reg;
            hrdata      <= rd_take ? rd_word : hrdata;
            hreadyout   <= 1'b1;
            hresp       <= pin_select_pkg::HRESP_OKAY;
        end
    end

    // mode and protect registers; reset leaves the select bank protected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_mode_bits_reg      <= pin_select_pkg::PORT_MODE_RESET[NPINS-1:0];
            protect_lock_bit_reg    <= pin_select_pkg::LOCK_RESET;
            select_write_enable_reg <= pin_select_pkg::WREN_RESET;
        end else begin
            port_mode_bits_reg      <= wr_mode ? hwdata[NPINS-1:0] : port_mode_bits_reg;
            protect_lock_bit_reg    <= lock_next;
            select_write_enable_reg <= wren_next;
        end
    end

    // select bank; no check against the mode bit, software must clear it first
    // or the pin may glitch while the code changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int unsigned i = 0; i < NPINS; i++) begin
                pin_function_select_reg[i] <= pin_select_pkg::SEL_RESET;
            end
        end else begin
            for (int unsigned i = 0; i < NPINS; i++) begin
                if (sel_wr_hit[i]) begin
                    pin_function_select_reg[i] <= hwdata[pin_select_pkg::SEL_WIDTH-1:0];
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // per-pin routing

    logic [NPINS-1:0]     periph_oe_route;

    // the receive pin is input only, so its peripheral enable never reaches the pad
    assign periph_oe_route = periph_oe & ~(NPINS'(1) << pin_select_pkg::PIN_DATA_IN);

    // mode clear gives the port, mode set with the serial code gives the peripheral;
    // each cell registers its pad drive, so a pin switches one edge after the write
    for (genvar p = 0; p < NPINS; p++) begin : g_pin
        pin_route_cell u_cell (
            .hclk                (hclk),
            .hresetn             (hresetn),
            .port_mode_bit       (port_mode_bits_reg[p]),
            .pin_function_select (pin_function_select_reg[p]),
            .gpio_out            (gpio_out[p]),
            .gpio_oe             (gpio_oe[p]),
            .gpio_in             (gpio_in[p]),
            .periph_out          (periph_out[p]),
            .periph_oe           (periph_oe_route[p]),
            .periph_in           (periph_in[p]),
            .pad_in              (pad_in[p]),
            .pad_out             (pad_out[p]),
            .pad_oe              (pad_oe[p])
        );
    end

endmodule : pin_function_select_protect

/* File: pfs_monitor.sv */
`timescale 1ns/1ps
module pfs_monitor #(
    parameter int unsigned NPINS = 3
) (
    // clock and reset
    input wire logic             hclk,
    input wire logic             hresetn,
    // bus request and write data
    input wire logic             hsel,
    input wire logic [11:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    // pin side
    input wire logic [NPINS-1:0] gpio_out,
    input wire logic [NPINS-1:0] gpio_oe,
    input wire logic [NPINS-1:0] gpio_in,
    input wire logic [NPINS-1:0] periph_out,
    input wire logic [NPINS-1:0] periph_oe,
    input wire logic [NPINS-1:0] periph_in,
    input wire logic [NPINS-1:0] pad_in,
    input wire logic [NPINS-1:0] pad_out,
    input wire logic [NPINS-1:0] pad_oe
);
    logic             wr_q;
    logic [11:0]      adr_q;
    logic [NPINS-1:0] mode_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    // mode bits mirrored from bus writes; only they are tracked, selects stay hidden
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'h0;
            adr_q  <= 12'h000;
            mode_q <= '0;
        end else begin
            wr_q  <= hsel && hready && htrans[1] && hwrite;
            adr_q <= haddr;
            if (wr_q && adr_q == pin_select_pkg::OFS_PORT_MODE)
                mode_q <= hwdata[NPINS-1:0];
        end
    end
    // past(hresetn) keeps the first edge after release out of reach
    gpio_copy_a: assert property ($past(hresetn) |-> gpio_in == $past(pad_in))
        else $error("gpio_in is not pad_in one edge late");
    port_oe_a: assert property ($past(hresetn) |->
        ((pad_oe ^ $past(gpio_oe)) & ~$past(mode_q)) == '0)
        else $error("port pin enable differs from gpio_oe");
    port_out_a: assert property ($past(hresetn) |->
        ((pad_out ^ $past(gpio_out)) & $past(gpio_oe & ~mode_q)) == '0)
        else $error("port pin level differs from gpio_out");
    rx_input_a: assert property ($past(hresetn) && $past(mode_q[0]) |-> !pad_oe[0])
        else $error("receive pin driven in peripheral mode");
    tx_drive_a: assert property ($past(hresetn) |-> (pad_oe & $past(mode_q & ~periph_oe)) == '0)
        else $error("peripheral pin driven without peripheral enable");
    tx_value_a: assert property ($past(hresetn) |->
        ((pad_out ^ $past(periph_out)) & pad_oe & $past(mode_q)) == '0)
        else $error("peripheral pin level differs from periph_out");
    periph_idle_a: assert property ($past(hresetn) |-> (~periph_in & $past(pad_in | ~mode_q)) == '0)
        else $error("peripheral input low without a routed low pin");
endmodule : pfs_monitor

bind pin_function_select_protect pfs_monitor #(.NPINS(NPINS)) i_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe));

/* File: pin_partner_model.sv */
`timescale 1ns/1ps
module pin_partner_model (
    // clock
    input wire logic       hclk,
    // package pins
    input wire logic [2:0] pad_out,
    input wire logic [2:0] pad_oe,
    output logic [2:0]     pad_in,
    // level the far slave puts on the receive pin
    input wire logic       rx_level
);
    logic [2:0] float_reg = 3'h5;
    // undriven transmit and clock lines keep changing, so a stale level never passes as a match
    always_ff @(posedge hclk) begin
        float_reg <= ~float_reg;
    end
    // the slave drives the receive pin whenever the device does not
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & {float_reg[2:1], rx_level});
endmodule : pin_partner_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [2:0] md, go, goe, po, poe;
        logic       rx;
        logic [2:0] e_oe, e_out;
        logic       e_pin, e_gin;
    } row_type;
    localparam logic [11:0] MD = pin_select_pkg::OFS_PORT_MODE;
    localparam logic [11:0] WP = pin_select_pkg::OFS_WRITE_PROTECT;
    localparam logic [11:0] FS = pin_select_pkg::OFS_FUNC_SEL_BASE;
    localparam logic [31:0] Z  = 32'h0000_0000;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_level;
    logic [1:0]  htrans;
    logic [11:0] haddr;
    logic [31:0] hwdata, hrdata, rd;
    logic [2:0]  gpio_out, gpio_oe, gpio_in, periph_out, periph_oe, periph_in, pad_in, pad_out, pad_oe;
    int          error_cnt, checks_done;
    row_type     rows [4] = '{{3'h0, 3'h5, 3'h6, 3'h2, 3'h7, 1'h0, 3'h6, 3'h4, 1'h1, 1'h0},
                              {3'h7, 3'h0, 3'h7, 3'h6, 3'h7, 1'h0, 3'h6, 3'h6, 1'h0, 1'h0},
                              {3'h7, 3'h0, 3'h7, 3'h0, 3'h3, 1'h1, 3'h2, 3'h0, 1'h1, 1'h1},
                              {3'h2, 3'h7, 3'h5, 3'h0, 3'h2, 1'h0, 3'h7, 3'h5, 1'h1, 1'h1}};
    pin_function_select_protect i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe));
    pin_partner_model i_far (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in), .rx_level(rx_level));
    ////////////////////////////////////////
    // free-running bus clock
    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // waits for hready at a rising edge, never longer than the bound
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'h1) begin
            n++;
            if (n > 20) begin
                chk("hready wait", 32'(n), Z);
                give_verdict();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    // one single transfer: address phase, then an idle data phase
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'h1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= pin_select_pkg::HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'(hresp), 32'(pin_select_pkg::HRESP_OKAY));
    endtask : xfer
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, rx_level} = '0;
        {gpio_out, gpio_oe, periph_out, periph_oe} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        // unlock, route all pins to the serial code with modes clear, relock
        xfer(1'h1, WP, Z);
        xfer(1'h1, WP, 32'h0000_0040);
        for (int p = 0; p < 3; p++)
            xfer(1'h1, FS + 12'(4 * p), 32'h0000_000A);
        xfer(1'h1, WP, Z);
        xfer(1'h1, WP, 32'h0000_0080);
        // mode and pin levels against the expected pin behaviour
        foreach (rows[i]) begin
            xfer(1'h1, MD, 32'(rows[i].md));
            {gpio_out, gpio_oe, periph_out, periph_oe, rx_level} <= rows[i][20:8];
            repeat (4) @(posedge hclk);
            chk("pad_oe", 32'(pad_oe), 32'(rows[i].e_oe));
            chk("pad_out", 32'(pad_out & rows[i].e_oe), 32'(rows[i].e_out));
            chk("rx periph_in", 32'(periph_in[0]), 32'(rows[i].e_pin));
            chk("rx gpio_in", 32'(gpio_in[0]), 32'(rows[i].e_gin));
        end
        // select write with write-enable clear, enable write while locked
        xfer(1'h1, MD, Z);
        xfer(1'h1, FS, Z);
        xfer(1'h0, FS, Z);
        chk("select kept", rd, 32'h0000_000A);
        xfer(1'h1, WP, 32'h0000_00C0);
        xfer(1'h0, WP, Z);
        chk("locked enable", rd, 32'h0000_0080);
        xfer(1'h1, WP, Z);
        xfer(1'h1, WP, 32'h0000_0040);
        xfer(1'h0, WP, Z);
        chk("open enable", rd, 32'h0000_0040);
        xfer(1'h1, FS + 12'h008, 32'hFFFF_FFFF);
        xfer(1'h0, FS + 12'h008, Z);
        chk("select width", rd, 32'h0000_001F);
        xfer(1'h0, 12'h0FC, Z);
        chk("unmapped", rd, Z);
        // all modes set with the high-impedance code; pins stay undriven and peripheral inputs idle
        for (int p = 0; p < 3; p++)
            xfer(1'h1, FS + 12'(4 * p), Z);
        xfer(1'h1, WP, Z);
        xfer(1'h1, WP, 32'h0000_0080);
        xfer(1'h1, MD, 32'h0000_0007);
        periph_out <= 3'h7;
        periph_oe  <= 3'h7;
        repeat (4) @(posedge hclk);
        chk("high-z pad_oe", 32'(pad_oe), Z);
        chk("idle periph_in", 32'(periph_in), 32'h0000_0007);
        // second reset in mid-run restores protected defaults
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        xfer(1'h0, MD, Z);
        chk("mode reset", rd, Z);
        xfer(1'h0, WP, Z);
        chk("protect reset", rd, 32'h0000_0080);
        for (int p = 0; p < 3; p++) begin
            xfer(1'h0, FS + 12'(4 * p), Z);
            chk("select reset", rd, Z);
        end
        give_verdict();
    end
endmodule : tb_top
